// ---- rtl/rim_pkg.sv ----
package rim_pkg;
	// Bus address and memory shape
	localparam logic [6:0] RIM_SLAVE_ADDR = 7'h6B;
	localparam int RIM_ADDR_W = 8;
	localparam int RIM_MEM_DEPTH = 256;
	localparam int RIM_ROW_BYTES = 8;
	localparam int RIM_ROW_BITS = 3;
	// Nonvolatile write time in microseconds, and its cycle count at 100 MHz
	localparam int RIM_CLK_MHZ = 100;
	localparam int RIM_NV_WRITE_TIME_US = 10;
	localparam int RIM_NV_WRITE_CYCLES = RIM_NV_WRITE_TIME_US * RIM_CLK_MHZ;
	localparam logic [7:0] RIM_RESET_BYTE = 8'h00;
endpackage

// ---- rtl/rim_sync.sv ----
`timescale 1ns/10ps
// Two-flop synchroniser for one pin
module rim_sync (
	input wire logic clock,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	logic meta;

	// First flop is read only by the second
	always_ff @(posedge clock) begin
		if (!resetn) begin
			meta <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// ---- rtl/rim_slave.sv ----
`timescale 1ns/10ps
// What this block does
// - Write past row end wraps within row
// - Commit bytes for write time after STOP
// - No address acknowledge while committing
// - Reads start at address counter
// - Dummy write loads the address counter
// - Reads continue while master acknowledges
// - Data line only pulled low or released
// - Write stores one to eight bytes
// - Respond to address 1101011 only
// - Commit on STOP, not repeated START
// - Event high rejects writes
module rim_slave #(
	parameter int NV_CYCLES = rim_pkg::RIM_NV_WRITE_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic event_in,
	output logic busy
);
	import rim_pkg::*;

	typedef enum {
		RIM_IDLE, RIM_ADDR, RIM_ADDR_ACK, RIM_MADDR, RIM_MADDR_ACK,
		RIM_WDATA, RIM_WDATA_ACK, RIM_RDATA, RIM_RDATA_ACK
	} rim_state_e;

	rim_state_e state;
	logic scl, sda, scl_d, sda_d, event_s;
	logic [7:0] mem [RIM_MEM_DEPTH];
	logic [7:0] pend [RIM_ROW_BYTES];
	logic [RIM_ROW_BYTES-1:0] pend_v;
	logic [RIM_ADDR_W-1:0] addr_cnt;
	logic [RIM_ADDR_W-1:0] row_base;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic rnw, drive_low, wr_pending;
	logic [31:0] nv_cnt;
	logic scl_rise, scl_fall, start_c, stop_c;

	rim_sync u_sync_scl (.clock(clock), .resetn(resetn), .din(scl_in), .dout(scl));
	rim_sync u_sync_sda (.clock(clock), .resetn(resetn), .din(sda_in), .dout(sda));
	rim_sync u_sync_evt (.clock(clock), .resetn(resetn), .din(event_in), .dout(event_s));

	// Edge and condition detection on synchronised lines
	always_ff @(posedge clock) begin
		if (!resetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_c = scl & scl_d & sda_d & ~sda;
	assign stop_c = scl & scl_d & ~sda_d & sda;

	// Open-drain data line: only low or released
	assign sda_out = 1'b0;
	assign sda_oe = drive_low;
	assign busy = nv_cnt != 32'd0;

	// Protocol engine
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= RIM_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			rnw <= 1'b0;
			drive_low <= 1'b0;
			addr_cnt <= '0;
			row_base <= '0;
			pend_v <= '0;
			wr_pending <= 1'b0;
		end else if (start_c) begin
			// Repeated START drops pending bytes without a commit
			state <= RIM_ADDR;
			bitcnt <= 4'h0;
			drive_low <= 1'b0;
			pend_v <= '0;
			wr_pending <= 1'b0;
		end else if (stop_c) begin
			state <= RIM_IDLE;
			drive_low <= 1'b0;
			pend_v <= '0;
			wr_pending <= 1'b0;
		end else begin
			unique case (state)
				RIM_IDLE: begin
					drive_low <= 1'b0;
				end
				RIM_ADDR, RIM_MADDR, RIM_WDATA: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda};
						bitcnt <= bitcnt + 4'h1;
					end
					if (scl_fall && bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						if (state == RIM_ADDR) begin
							rnw <= shreg[0];
							// Match address, not busy, writes barred while event high
							if (shreg[7:1] == RIM_SLAVE_ADDR && !busy
								&& !(event_s && !shreg[0])) begin
								state <= RIM_ADDR_ACK;
								drive_low <= 1'b1;
							end else begin
								state <= RIM_IDLE;
							end
						end else if (state == RIM_MADDR) begin
							addr_cnt <= shreg;
							row_base <= {shreg[7:RIM_ROW_BITS], {RIM_ROW_BITS{1'b0}}};
							state <= RIM_MADDR_ACK;
							drive_low <= 1'b1;
						end else begin
							// Stage byte; column wraps inside the row
							pend[addr_cnt[RIM_ROW_BITS-1:0]] <= shreg;
							pend_v[addr_cnt[RIM_ROW_BITS-1:0]] <= 1'b1;
							wr_pending <= 1'b1;
							addr_cnt <= row_base | {5'h00, 3'(addr_cnt[2:0] + 3'h1)};
							state <= RIM_WDATA_ACK;
							drive_low <= 1'b1;
						end
					end
				end
				RIM_ADDR_ACK, RIM_MADDR_ACK, RIM_WDATA_ACK: begin
					if (scl_fall) begin
						if (state == RIM_ADDR_ACK && rnw) begin
							shreg <= mem[addr_cnt];
							drive_low <= ~mem[addr_cnt][7];
							state <= RIM_RDATA;
							bitcnt <= 4'h1;
						end else begin
							drive_low <= 1'b0;
							state <= (state == RIM_ADDR_ACK) ? RIM_MADDR : RIM_WDATA;
						end
					end
				end
				RIM_RDATA: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							drive_low <= 1'b0; // Release for master ack
							state <= RIM_RDATA_ACK;
							addr_cnt <= addr_cnt + 8'h01;
						end else begin
							drive_low <= ~shreg[7 - bitcnt[2:0]];
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				RIM_RDATA_ACK: begin
					if (scl_rise) begin
						// Master ACK asks for the next byte; NACK ends it
						rnw <= ~sda;
					end
					if (scl_fall) begin
						if (rnw) begin
							shreg <= mem[addr_cnt];
							drive_low <= ~mem[addr_cnt][7];
							state <= RIM_RDATA;
							bitcnt <= 4'h1;
						end else begin
							state <= RIM_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Commit staged bytes after STOP, then hold busy for the write time
	always_ff @(posedge clock) begin
		if (!resetn) begin
			nv_cnt <= 32'd0;
		end else if (stop_c && wr_pending) begin
			nv_cnt <= 32'(NV_CYCLES);
		end else if (nv_cnt != 32'd0) begin
			nv_cnt <= nv_cnt - 32'd1;
		end
	end

	// Memory array update on STOP
	always_ff @(posedge clock) begin
		if (stop_c && wr_pending) begin
			for (int i = 0; i < RIM_ROW_BYTES; i++) begin
				if (pend_v[i]) begin
					mem[row_base | 8'(i)] <= pend[i];
				end
			end
		end
	end

	// Checks
	a_busy_after_stop: assert property (@(posedge clock) disable iff (!resetn)
		(stop_c && wr_pending) |=> busy [*8])
		else $error("busy not held after write stop");
	a_no_ack_busy: assert property (@(posedge clock) disable iff (!resetn)
		(busy && state == RIM_ADDR && scl_fall && bitcnt == 4'h8) |=> !drive_low)
		else $error("address acknowledged while busy");
	a_sda_od: assert property (@(posedge clock) disable iff (!resetn)
		sda_oe |-> !sda_out)
		else $error("data line driven high");
	a_row_wrap: assert property (@(posedge clock) disable iff (!resetn)
		(state == RIM_WDATA && scl_fall && bitcnt == 4'h8 && !start_c && !stop_c)
		|=> addr_cnt[7:3] == $past(addr_cnt[7:3]))
		else $error("write counter left its row");
	a_event_block: assert property (@(posedge clock) disable iff (!resetn)
		(event_s && state == RIM_ADDR && scl_fall && bitcnt == 4'h8 && !shreg[0]
		&& !start_c && !stop_c) |=> state == RIM_IDLE)
		else $error("write accepted while event high");
	a_rd_incr: assert property (@(posedge clock) disable iff (!resetn)
		(state == RIM_RDATA && scl_fall && bitcnt == 4'h8 && !start_c && !stop_c)
		|=> addr_cnt == $past(addr_cnt) + 8'h01)
		else $error("read counter not advanced");
	a_rs_nocommit: assert property (@(posedge clock) disable iff (!resetn)
		(start_c && !busy) |=> !busy)
		else $error("repeated start began a commit");
	a_addr_nomatch: assert property (@(posedge clock) disable iff (!resetn)
		(state == RIM_ADDR && scl_fall && bitcnt == 4'h8 && shreg[7:1] != RIM_SLAVE_ADDR
		&& !start_c && !stop_c) |=> state == RIM_IDLE && !drive_low)
		else $error("foreign address acknowledged");
	c_write: cover property (@(posedge clock) stop_c && wr_pending);
	c_read_next: cover property (@(posedge clock) state == RIM_RDATA_ACK && scl_fall && rnw);
	c_poll_nack: cover property (@(posedge clock) busy && state == RIM_ADDR && bitcnt == 4'h8);
endmodule

// ---- tb/rim_master.sv ----
`timescale 1ns/10ps
// Bus master model: owns the bus clock, pulls data low or releases it
module rim_master (
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic go(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Start or repeated start: data falls while clock is high
	task automatic start();
		go(1);
		sda_oe = 1'b0;
		go(3);
		scl = 1'b1;
		go(4);
		sda_oe = 1'b1;
		go(4);
		scl = 1'b0;
	endtask
	// Stop: data rises while clock is high, then the clock stands still
	task automatic stop();
		go(1);
		sda_oe = 1'b1;
		go(3);
		scl = 1'b1;
		go(4);
		sda_oe = 1'b0;
		go(4);
	endtask
	// Nine bits MSB first; each bit is sampled just before the clock falls
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			go(1);
			sda_oe = !w[i];
			go(3);
			scl = 1'b1;
			go(4);
			r[i] = sda;
			scl = 1'b0;
		end
	endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
	import rim_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic event_in = 1'b0;
	logic scl, m_oe, sda_out, sda_oe, busy;
	logic [8:0] r9;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	// Open-drain data wire with pull-up; the slave shows its driven value only while enabled
	wire sda = (sda_oe ? sda_out : 1'b1) && !m_oe;
	always #5 clock = ~clock;
	rim_master rim_master_inst (.clock(clock), .sda(sda), .scl(scl), .sda_oe(m_oe));
	// Write time long enough that the first poll still finds the slave busy
	rim_slave #(.NV_CYCLES(150)) rim_slave_inst (.clock(clock), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.event_in(event_in), .busy(busy));
	task summarize;
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Send a byte and compare the acknowledge bit (0 = acknowledged)
	task sa(input logic [7:0] b, input logic e);
		rim_master_inst.xfer({b, 1'b1}, r9);
		check({7'h0, r9[0]}, {7'h0, e});
	endtask
	// Read a byte, answer with ack or nack, compare the data
	task rd(input logic last, input logic [7:0] e);
		rim_master_inst.xfer({8'hFF, last}, r9);
		check(r9[8:1], e);
	endtask
	// Row wrap, commit time and acknowledge polling
	task t_wrap;
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h06, 1'b0);
		for (int i = 1; i <= 4; i++) sa(8'(i * 17), 1'b0);
		rim_master_inst.stop();
		check({7'h0, busy}, 8'h01);
		rim_master_inst.start();
		sa(8'hD6, 1'b1);
		rim_master_inst.stop();
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clock);
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h06, 1'b0);
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b1, 8'h11);
		rim_master_inst.stop();
	endtask
	// Current-address read, then sequential read across the wrapped row
	task t_read;
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b1, 8'h22);
		rim_master_inst.stop();
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h00, 1'b0);
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b0, 8'h33);
		rd(1'b1, 8'h44);
		rim_master_inst.stop();
		check({7'h0, sda_out}, 8'h00);
	endtask
	// Foreign address, repeated start without commit, event lockout
	task t_refuse;
		rim_master_inst.start();
		sa(8'hA0, 1'b1);
		sa(8'h00, 1'b1);
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h06, 1'b0);
		sa(8'h5A, 1'b0);
		rim_master_inst.start();
		check({7'h0, busy}, 8'h00);
		sa(8'hD7, 1'b0);
		rd(1'b1, 8'h22);
		rim_master_inst.stop();
		check({7'h0, busy}, 8'h00);
		// The dropped byte must not have reached the array
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h06, 1'b0);
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b1, 8'h11);
		rim_master_inst.stop();
		@(negedge clock) event_in = 1'b1;
		rim_master_inst.go(4);
		rim_master_inst.start();
		sa(8'hD6, 1'b1);
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b1, 8'h22);
		rim_master_inst.stop();
		event_in = 1'b0;
	endtask
	// Stop at the row end, wait out the write time, continue in the next row
	task t_cross;
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h0E, 1'b0);
		sa(8'hAA, 1'b0);
		sa(8'hBB, 1'b0);
		rim_master_inst.stop();
		rim_master_inst.go(200);
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h10, 1'b0);
		sa(8'hCC, 1'b0);
		rim_master_inst.stop();
		rim_master_inst.go(200);
		rim_master_inst.start();
		sa(8'hD6, 1'b0);
		sa(8'h0E, 1'b0);
		rim_master_inst.start();
		sa(8'hD7, 1'b0);
		rd(1'b0, 8'hAA);
		rd(1'b0, 8'hBB);
		rd(1'b1, 8'hCC);
		rim_master_inst.stop();
	endtask
	// Cut a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			summarize;
		end
	end
	// Reset, then the scenarios in order
	initial begin
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		repeat (5) @(negedge clock);
		t_wrap;
		t_read;
		t_cross;
		t_refuse;
		summarize;
	end
endmodule
